/* File: bench/ser_rx_model.sv */
`timescale 1ns/1ps
`include "ser_params.svh"

// Far-end receiver: keeps bit 0 of each lane at a forwarded clock rise
module ser_rx_model
(
  input  wire logic                  clk,
  input  wire logic                  fclk,
  input  wire logic [`SER_LANES-1:0] lanes,
  output logic      [`SER_LANES-1:0] slice,
  output logic                       stb,
  output logic      [`SER_WORD-1:0]  word,
  output logic                       word_stb
);
  logic       fclk_q = 1'b0;
  logic [2:0] pos    = 3'h7;
  // Strict compare keeps an unknown clock before reset from jamming pos
  wire        rise   = (fclk === 1'b1) && (fclk_q === 1'b0);
  wire        take   = rise || (pos != 3'h7);
  wire  [2:0] slot   = rise ? 3'h0 : pos;
  // Lanes are taken on the same edge as the rise, so both stay in step
  always_ff @(posedge clk)
  begin
    fclk_q <= fclk;
    stb    <= rise;
    slice  <= lanes;
  end
  // Seven samples per lane from the rise rebuild the word, LSB first
  always_ff @(posedge clk)
  begin
    pos      <= take ? ((slot == 3'h6) ? 3'h7 : slot + 3'h1) : 3'h7;
    word_stb <= take && (slot == 3'h6);
    if (take)
      for (int k = 0; k < `SER_LANES; k++)
        word[k*`SER_BITS + slot] <= lanes[k];
  end
endmodule

/* File: bench/ser_serializer_monitor.sv */
`timescale 1ns/1ps
`include "ser_params.svh"

module ser_serializer_monitor
#(parameter int LOCK_CYCLES = `SER_LOCK_CYC)
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  parallel_clock_in,
  input wire logic [`SER_WORD-1:0]  parallel_data_in,
  input wire logic                  shutdown_clear_n,
  input wire logic [`SER_LANES-1:0] serial_lane_out,
  input wire logic                  forwarded_clock_out,
  input wire logic                  driver_enable_n
);
  wire                fco = forwarded_clock_out;
  wire                den = driver_enable_n;
  wire [`SER_WORD-1:0] d  = parallel_data_in;
  logic [31:0]        up;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Time since reset or shutdown was last low; lock is measured from it
  always_ff @(posedge clk)
    up <= (!rst_n || !shutdown_clear_n) ? 32'h0000_0000 : up + 32'h0000_0001;
  // Four low samples: the pin sync has passed the clear through
  sequence s_off; !shutdown_clear_n[*4]; endsequence
  property p_clr; s_off |-> serial_lane_out == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("lanes set");
  property p_off; s_off |-> den && !fco; endproperty
  a_off: assert property (p_off) else $error("drivers on");
  property p_lock; $fell(den) |-> up >= LOCK_CYCLES; endproperty
  a_lock: assert property (p_lock) else $error("early lock");
  // Run waits for a word boundary, up to one word period more
  property p_up; up == LOCK_CYCLES + 16 |-> !den; endproperty
  a_up: assert property (p_up) else $error("no lock");
  // Forwarded clock: four bit slots high, then at least three low
  property p_hi;
    disable iff (!rst_n || !shutdown_clear_n)
    $rose(fco) |-> fco[*4] ##[1:2] !fco;
  endproperty
  a_hi: assert property (p_hi) else $error("high time");
  property p_lo; $fell(fco) |-> !fco[*3]; endproperty
  a_lo: assert property (p_lo) else $error("low time");
  property p_fwd;
    $rose(parallel_clock_in) && !den |-> ##[3:7] ($rose(fco) || den);
  endproperty
  a_fwd: assert property (p_fwd) else $error("no clock out");
  property p_map;
    $rose(fco) && !den |->
      serial_lane_out == {$past(d[14], 4), $past(d[7], 4), $past(d[0], 4)};
  endproperty
  a_map: assert property (p_map) else $error("lane order");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind ser_serializer ser_serializer_monitor
  #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon
(
  .clk                 (clk),
  .rst_n               (rst_n),
  .parallel_clock_in   (parallel_clock_in),
  .parallel_data_in    (parallel_data_in),
  .shutdown_clear_n    (shutdown_clear_n),
  .serial_lane_out     (serial_lane_out),
  .forwarded_clock_out (forwarded_clock_out),
  .driver_enable_n     (driver_enable_n)
);

/* File: bench/ser_serializer_tb.sv */
`timescale 1ns/1ps
`include "ser_params.svh"

module ser_serializer_tb;
  localparam int LOCK = 20;
  logic clk = 1'b0, rst_n = 1'b0, pclk = 1'b0, shdn_n = 1'b1;
  logic den_n, fclk, stb, wstb;
  logic [2:0] ph = 3'h0;
  logic [`SER_LANES-1:0] lanes, slice;
  logic [`SER_WORD-1:0] data = 21'h00_0000, sent, sent_q, word;
  logic [31:0] seed = 32'h0000_d4af;
  int error_cnt = 0, total_checks = 0;

  ser_serializer #(.LOCK_CYCLES(LOCK)) DUT (.clk(clk), .rst_n(rst_n),
    .parallel_clock_in(pclk), .parallel_data_in(data),
    .shutdown_clear_n(shdn_n), .serial_lane_out(lanes),
    .forwarded_clock_out(fclk), .driver_enable_n(den_n));
  ser_rx_model u_rx (.clk(clk), .fclk(fclk), .lanes(lanes), .slice(slice),
    .stb(stb), .word(word), .word_stb(wstb));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] exp_slice(input logic [20:0] w);
    return {w[14], w[7], w[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for lock, then skip the unmeasured first periods
  task automatic wait_on();
    int n;
    n = 0;
    while (den_n !== 1'b0 && n < LOCK + 50)
    begin
      @(negedge clk);
      n++;
    end
    check(den_n, 0);
    repeat (16) @(negedge clk);
  endtask
  task automatic run_words(input int n);
    int k, s;
    s = 0;
    for (k = 0; k < n * 8; k++)
    begin
      @(negedge clk);
      if (stb === 1'b1)
      begin
        s++;
        check(slice, exp_slice(sent));
      end
      // Whole word lands four cycles after the next input rise
      if (wstb === 1'b1)
        check(word, sent_q);
    end
    check(s >= n - 1 && s <= n + 1, 1);
    $display("test of %0d words done", n);
  endtask
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Word clock of eight cycles; data moves at its fall, far from capture
  always @(negedge clk)
  begin
    ph <= ph + 3'h1;
    pclk <= ph[2];
    if (ph == 3'h4)
    begin
      sent_q <= sent;
      sent   <= data;
    end
    if (ph == 3'h0)
    begin
      seed <= lfsr(seed);
      data <= (seed[3:0] == 4'h0) ? 21'h1f_ffff : seed[20:0];
    end
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    wait_on();
    run_words(40);
    shdn_n = 1'b0;
    repeat (10) @(negedge clk);
    check(lanes, 0);
    check(fclk, 0);
    check(den_n, 1);
    $display("test of shutdown done");
    shdn_n = 1'b1;
    wait_on();
    run_words(20);
    end_sim();
  end
  // Run is near 600 cycles; over eleven times that is a hang
  initial
  begin
    #175us;
    error_cnt++;
    $display("watchdog expired");
    end_sim();
  end
endmodule

/* File: pkg/ser_params.svh */
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH

// Lane geometry
`define SER_LANES          3
`define SER_BITS           7
`define SER_WORD           21
// Forwarded clock stays high for this many bit slots
`define SER_FCLK_HIGH      4
// Clock rate of the block
`define SER_CLK_MHZ        40
// Typical lock time after release, in microseconds
`define SER_LOCK_US        1000
// Typical disable time, in nanoseconds
`define SER_DISABLE_NS     250
`define SER_CLK_NS         25
// Cycles of clk allowed to reach the off state (rounded down)
`define SER_DISABLE_CYC    (`SER_DISABLE_NS / `SER_CLK_NS)
// Cycles of clk to wait for lock
`define SER_LOCK_CYC       (`SER_LOCK_US * `SER_CLK_MHZ)
// Width of the input clock period counter
`define SER_PER_W          8

`endif

/* File: pkg/ser_pkg.sv */
package ser_pkg;

  // Power state, Gray coded along off -> locking -> run
  typedef enum logic [1:0]
  {
    SER_OFF  = 2'b00,
    SER_LOCK = 2'b01,
    SER_RUN  = 2'b11
  } ser_state_t;

endpackage

/* File: src/ser_lane_shift.sv */
`timescale 1ns/1ps
`include "ser_params.svh"

// Parallel-load, serial-out register for one lane, LSB first
module ser_lane_shift
(
  input  wire logic                  clk,
  input  wire logic                  clear,
  input  wire logic                  load,
  input  wire logic                  shift,
  input  wire logic [`SER_BITS-1:0]  par,
  output logic                       ser_out
);

  logic [`SER_BITS-1:0] sh;

  // Clear wins over load, load over shift
  always_ff @(posedge clk)
  begin
    if (clear)
      sh <= '0;
    else if (load)
      sh <= par;
    else if (shift)
      sh <= {1'b0, sh[`SER_BITS-1:1]};
  end

  assign ser_out = sh[0];

endmodule

/* File: src/ser_serializer.sv */
`timescale 1ns/1ps
`include "ser_params.svh"

// Function
// RULE1: Capture all 21 inputs on input clock rise
// RULE2: Three 7-bit parallel-load serial-out registers
// RULE3: Bit rate is seven times input clock
// RULE4: Three lanes plus forwarded clock drive out
// RULE5: Forwarded clock matches input clock frequency
// RULE6: Shutdown low stops clock, drivers off
// RULE7: Shutdown low clears every internal register (the pin synchronisers clear on rst_n only)
// RULE8: Input clock 20 to 68 MHz locks (the code serialises input clocks only up to clk/7)
// RULE9: Lanes valid about 1 ms after release
// RULE10: Off state, clock low, within 250 ns
// RULE11: Forwarded clock high four of seven bits
// RULE12: Captured word shifts out next input period
// RULE13: Lane k bit j is input 7k+j
module ser_serializer
  import ser_pkg::*;
#(
  parameter int LOCK_CYCLES = `SER_LOCK_CYC
)
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  parallel_clock_in,
  input  wire logic [`SER_WORD-1:0]  parallel_data_in,
  input  wire logic                  shutdown_clear_n,
  output logic [`SER_LANES-1:0]      serial_lane_out,
  output logic                       forwarded_clock_out,
  output logic                       driver_enable_n
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic                 pclk_s1;
  logic                 pclk_s2;
  logic                 pclk_s3;
  logic                 sd_s1;
  logic                 sd_s2;
  logic [`SER_WORD-1:0] data_s1;
  logic [`SER_WORD-1:0] data_s2;

  // Data passes the same two stages as the clock, so they stay aligned
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_s3 <= 1'b0;
      sd_s1   <= 1'b0;
      sd_s2   <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end
    else
    begin
      pclk_s1 <= parallel_clock_in;
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
      sd_s1   <= shutdown_clear_n;
      sd_s2   <= sd_s1;
      data_s1 <= parallel_data_in;
      data_s2 <= data_s1;
    end
  end

  wire pclk_rise = pclk_s2 & ~pclk_s3;
  wire clear     = ~rst_n | ~sd_s2;       // see RULE7

  ////////////////////////////////////////////////////////////////////////
  // Lock sequencing

  ser_state_t state;
  ser_state_t next_state;
  logic [31:0] lock_cnt;
  logic        load_d;
  wire         lock_done = (lock_cnt >= 32'(LOCK_CYCLES - 1));

  // Model of the multiplier settling time after release
  // Run begins at a word load, so the first forwarded pulse is whole
  always_comb
  begin
    next_state = state;
    unique case (state)
      SER_OFF:  next_state = SER_LOCK;
      SER_LOCK: if (lock_done && load_d) next_state = SER_RUN; // see RULE9
      SER_RUN:  next_state = SER_RUN;
      default:  next_state = SER_OFF;
    endcase
  end

  // Shutdown drops straight to off, well inside the disable time
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      state    <= SER_OFF;                 // see RULE10
      lock_cnt <= '0;
    end
    else
    begin
      state    <= next_state;
      lock_cnt <= (state == SER_LOCK) ? lock_cnt + 32'd1 : '0;
    end
  end

  wire running = (state == SER_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Input period measure and bit-tick synthesis

  logic [`SER_PER_W-1:0] per_cnt;
  logic [`SER_PER_W-1:0] period;
  logic [`SER_PER_W:0]   acc;
  logic [2:0]            bit_idx;

  // Counter saturates, so a stopped input clock cannot wrap it
  wire per_max = &per_cnt;
  wire [`SER_PER_W:0] acc_sum = acc + (`SER_PER_W+1)'(`SER_BITS);
  // Fractional divider: seven ticks per measured input period
  wire bit_tick = (acc_sum >= {1'b0, period});        // see RULE3
  wire last_bit = (bit_idx == 3'(`SER_BITS - 1));
  wire do_shift = bit_tick & ~last_bit & ~load_d;

  always_ff @(posedge clk)
  begin
    if (clear)
      per_cnt <= '0;
    else if (pclk_rise)
      per_cnt <= (`SER_PER_W)'(1);
    else if (!per_max)
      per_cnt <= per_cnt + (`SER_PER_W)'(1);
  end

  // Limitation: the input clock must be at most clk/7 to fit seven bit slots
  always_ff @(posedge clk)
  begin
    if (clear)
      period <= '0;
    else if (pclk_rise)
      period <= per_cnt;                     // see RULE8
  end

  // Phase restarts on each load so bit 0 lines up with the word
  always_ff @(posedge clk)
  begin
    if (clear || load_d)
      acc <= '0;
    else if (bit_tick)
      acc <= acc_sum - {1'b0, period};
    else
      acc <= acc_sum;
  end

  always_ff @(posedge clk)
  begin
    if (clear || load_d)
      bit_idx <= '0;
    else if (do_shift)
      bit_idx <= bit_idx + 3'd1;             // see RULE12
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture and shift

  logic [`SER_WORD-1:0] capture;

  // Word of this edge is loaded one cycle later, after the old one ends
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      capture <= '0;
      load_d  <= 1'b0;
    end
    else
    begin
      if (pclk_rise)
        capture <= data_s2;                  // see RULE1
      load_d <= pclk_rise;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `SER_LANES; k++)
    begin : g_lane
      // Lane k carries inputs 7k..7k+6, lowest first
      ser_lane_shift u_shift
      (
        .clk     (clk),
        .clear   (clear),
        .load    (load_d),                   // see RULE2
        .shift   (do_shift),
        .par     (capture[k*`SER_BITS +: `SER_BITS]),  // see RULE13
        .ser_out (serial_lane_out[k])        // see RULE4
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Forwarded clock and driver enable

  // High in bit slots 0..3, one cycle per input cycle
  wire fclk_high = (bit_idx < 3'(`SER_FCLK_HIGH));

  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      forwarded_clock_out <= 1'b0;           // see RULE6
      driver_enable_n     <= 1'b1;
    end
    else
    begin
      forwarded_clock_out <= running & fclk_high;  // see RULE5, RULE11
      driver_enable_n     <= ~running;       // see RULE4
    end
  end

endmodule
